//--- dpp_pkg.sv
/*
 Package for the dual parallel port block: special register space offsets, reset values, widths.
 Assumes an 8-bit CPU register bus with a 6-bit address inside the special register space.
*/
`default_nettype none
package dpp_pkg;
    localparam int          DPP_ADDR_W         = 6;
    localparam int          DPP_DATA_W         = 8;
    localparam int          DPP_P1_W           = 8;
    localparam int          DPP_P2_W           = 3;
    localparam logic [15:0] DPP_SPACE_LO       = 16'h0000;
    localparam logic [15:0] DPP_SPACE_HI       = 16'h003F;
    localparam logic [5:0]  DPP_OFF_P1_LATCH   = 6'h01;
    localparam logic [5:0]  DPP_OFF_P2_LATCH   = 6'h02;
    localparam logic [5:0]  DPP_OFF_P1_PIN     = 6'h08;
    localparam logic [5:0]  DPP_OFF_P2_PIN     = 6'h09;
    localparam logic [5:0]  DPP_OFF_P1_SEG     = 6'h29;
    localparam logic [7:0]  DPP_P1_LATCH_RST   = 8'hFF;
    localparam logic [2:0]  DPP_P2_LATCH_RST   = 3'h7;
    localparam logic [7:0]  DPP_P1_SEG_RST     = 8'h00;
    localparam logic [7:0]  DPP_RD_FILL        = 8'h00;
    localparam int          DPP_P2_STOP_BIT    = 0;
    localparam int          DPP_P2_OSC_IN_BIT  = 1;
    localparam int          DPP_P2_OSC_OUT_BIT = 2;
endpackage : dpp_pkg
`default_nettype wire

//--- dpp_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes inputs are asynchronous to clk_sys; first stage feeds only the second.
*/
`default_nettype none
module dpp_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule : dpp_sync
`default_nettype wire

//--- dpp_ports.sv
/*
 Dual parallel port block: 8-bit port with LCD segment select, 3-bit port with
 oscillator pins and a stop-release input, reached over the CPU special register space.
 Assumes the CPU presents a one-cycle read strobe (sample phase) and a one-cycle write
 strobe (update phase); pins are open-drain sink drivers resolved by the surroundings.
*/
// Behaviour
// - Decode port registers only inside special register space 0000H to 003FH.
// - Each output bit keeps its latch value until rewritten.
// - Pin level is sampled in the read sample phase of the read cycle.
// - Output changes in the write update phase of the write cycle.
// - First port is 8 bits; segment select bit 1 makes pin LCD segment.
// - Reset sets every output latch bit of both ports to 1.
// - First port latch and pin-input registers sit at separate addresses.
// - Pin-input bit of a segment pin is undefined.
// - Dual-clock mode gives bits 1 and 2 to the low-frequency oscillator.
// - Falling edge on driven bit 0 sets the associated interrupt latch.
// - Second port latch and pin-input registers sit at separate addresses.
// - Second port read bits 7 to 3 are undefined.
// - In stop mode bit 0 floats regardless of the output enable.
`default_nettype none
module dpp_ports
    import dpp_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [15:0]           cpu_addr,
    input  wire logic [DPP_DATA_W-1:0] cpu_wdata,
    input  wire logic                  cpu_rd_sample,
    input  wire logic                  cpu_wr_update,
    output logic      [DPP_DATA_W-1:0] cpu_rdata,
    input  wire logic                  port_output_enable,
    input  wire logic                  dual_clock_mode,
    input  wire logic                  stop_mode,
    input  wire logic [DPP_P1_W-1:0]   port1_in,
    output logic      [DPP_P1_W-1:0]   port1_out,
    output logic      [DPP_P1_W-1:0]   port1_oe,
    output logic      [DPP_P1_W-1:0]   port1_lcd_seg_en,
    input  wire logic [DPP_P2_W-1:0]   port2_in,
    output logic      [DPP_P2_W-1:0]   port2_out,
    output logic      [DPP_P2_W-1:0]   port2_oe,
    output logic                       low_freq_osc_in,
    input  wire logic                  low_freq_osc_out,
    output logic                       port2_bit0_fall,
    output logic                       stop_release
);
    logic [DPP_P1_W-1:0]   p1_latch_r, p1_latch_nxt;
    logic [DPP_P1_W-1:0]   p1_seg_r, p1_seg_nxt;
    logic [DPP_P2_W-1:0]   p2_latch_r, p2_latch_nxt;
    logic [DPP_DATA_W-1:0] rdata_r, rdata_nxt;
    logic                  p20_drv_r, p20_drv_nxt;
    logic                  fall_r, fall_nxt;
    logic [DPP_P1_W-1:0]   p1_pin_s;
    logic [DPP_P2_W-1:0]   p2_pin_s;
    logic                  in_space;
    logic [5:0]            off;
    logic                  p20_drive;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        return in_space && (a == o);
    endfunction : hit

    dpp_sync #(.W(DPP_P1_W)) u_sync1 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (port1_in),
        .q       (p1_pin_s)
    );

    dpp_sync #(.W(DPP_P2_W)) u_sync2 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (port2_in),
        .q       (p2_pin_s)
    );

    assign in_space = (cpu_addr >= DPP_SPACE_LO) && (cpu_addr <= DPP_SPACE_HI);
    assign off      = cpu_addr[DPP_ADDR_W-1:0];

    always_comb begin
        p1_latch_nxt = p1_latch_r;
        p1_seg_nxt   = p1_seg_r;
        p2_latch_nxt = p2_latch_r;
        if (cpu_wr_update) begin
            if (hit(off, DPP_OFF_P1_LATCH)) begin
                p1_latch_nxt = cpu_wdata;
            end
            if (hit(off, DPP_OFF_P1_SEG)) begin
                p1_seg_nxt = cpu_wdata;
            end
            if (hit(off, DPP_OFF_P2_LATCH)) begin
                p2_latch_nxt = cpu_wdata[DPP_P2_W-1:0];
            end
        end
    end

    // Read data captured on the sample strobe and held until the next read
    always_comb begin
        rdata_nxt = rdata_r;
        if (cpu_rd_sample) begin
            rdata_nxt = DPP_RD_FILL;
            if (hit(off, DPP_OFF_P1_LATCH)) begin
                rdata_nxt = p1_latch_r;
            end else if (hit(off, DPP_OFF_P1_PIN)) begin
                // Segment pins return a meaningless synchronised pad level
                rdata_nxt = p1_pin_s;
            end else if (hit(off, DPP_OFF_P1_SEG)) begin
                rdata_nxt = p1_seg_r;
            end else if (hit(off, DPP_OFF_P2_LATCH)) begin
                rdata_nxt = {DPP_RD_FILL[7:3], p2_latch_r};
            end else if (hit(off, DPP_OFF_P2_PIN)) begin
                rdata_nxt = {DPP_RD_FILL[7:3], p2_pin_s};
            end
        end
    end

    assign p20_drive = port_output_enable && !stop_mode && !p2_latch_r[DPP_P2_STOP_BIT];

    // Edge detect on the driven level only; input-side edges belong to the interrupt block
    always_comb begin
        p20_drv_nxt = p20_drive;
        fall_nxt    = p20_drive && !p20_drv_r;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            p1_latch_r <= DPP_P1_LATCH_RST;
            p2_latch_r <= DPP_P2_LATCH_RST;
            p1_seg_r   <= DPP_P1_SEG_RST;
            rdata_r    <= DPP_RD_FILL;
            p20_drv_r  <= 1'b0;
            fall_r     <= 1'b0;
        end else begin
            p1_latch_r <= p1_latch_nxt;
            p2_latch_r <= p2_latch_nxt;
            p1_seg_r   <= p1_seg_nxt;
            rdata_r    <= rdata_nxt;
            p20_drv_r  <= p20_drv_nxt;
            fall_r     <= fall_nxt;
        end
    end

    assign cpu_rdata        = rdata_r;
    assign port1_lcd_seg_en = p1_seg_r;
    assign port1_out        = '0;
    // Sink driver enabled for latch 0, disabled when pin is a segment
    assign port1_oe         = {DPP_P1_W{port_output_enable}} & ~p1_latch_r & ~p1_seg_r;
    assign port2_out        = '0;

    always_comb begin
        port2_oe                     = {DPP_P2_W{port_output_enable}} & ~p2_latch_r;
        port2_oe[DPP_P2_STOP_BIT]    = p20_drive;
        if (dual_clock_mode) begin
            port2_oe[DPP_P2_OSC_IN_BIT]  = 1'b0;
            port2_oe[DPP_P2_OSC_OUT_BIT] = 1'b0;
        end
    end

    // Oscillator input taken from the synchronised pad; a real crystal bypasses this
    assign low_freq_osc_in = dual_clock_mode & p2_pin_s[DPP_P2_OSC_IN_BIT];
    assign port2_bit0_fall = fall_r;
    assign stop_release    = stop_mode & p2_pin_s[DPP_P2_STOP_BIT];
endmodule : dpp_ports
`default_nettype wire

//--- dpp_ports_assertions.sv
/* Port-level checker for dpp_ports.
 Bound from the bench top; assumes synchronous active-high rst on clk_sys. */
`default_nettype none
module dpp_ports_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0]  cpu_wdata,
    input wire logic        cpu_rd_sample,
    input wire logic        cpu_wr_update,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        port_output_enable,
    input wire logic        dual_clock_mode,
    input wire logic        stop_mode,
    input wire logic [7:0]  port1_oe,
    input wire logic [7:0]  port1_lcd_seg_en,
    input wire logic [2:0]  port2_out,
    input wire logic [2:0]  port2_oe,
    input wire logic        port2_bit0_fall
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_p1_drive: assert property (cpu_wr_update && cpu_addr == 16'h0001 |=>
        port1_oe == ({8{port_output_enable}} & ~$past(cpu_wdata) & ~port1_lcd_seg_en))
        else $error("port1 drive mismatch");
    a_seg_write: assert property (cpu_wr_update && cpu_addr == 16'h0029 |=>
        port1_lcd_seg_en == $past(cpu_wdata)) else $error("segment select mismatch");
    a_reset_init: assert property ($fell(rst) |-> port1_oe == 8'h00 && port2_oe == 3'h0)
        else $error("drivers on after reset");
    a_sink_only: assert property (port2_out == 3'h0) else $error("port2 drives high");
    a_stop_float: assert property (stop_mode |-> !port2_oe[0]) else $error("bit0 driven");
    a_osc_pins: assert property (dual_clock_mode |-> port2_oe[2:1] == 2'h0)
        else $error("oscillator pin driven");
    a_unmapped_rd: assert property (cpu_rd_sample && cpu_addr > 16'h003F |=>
        cpu_rdata == 8'h00) else $error("read outside space");
    a_rdata_hold: assert property (!cpu_rd_sample |=> $stable(cpu_rdata))
        else $error("read data moved");
    a_fall_pulse: assert property ($rose(port2_oe[0]) |-> ##[0:1] port2_bit0_fall)
        else $error("no fall pulse");
    c_fall: cover property (port2_bit0_fall);
    c_seg: cover property (port1_lcd_seg_en != 8'h00);
    c_stop: cover property (stop_mode && dual_clock_mode);
endmodule : dpp_ports_assertions
`default_nettype wire

//--- dpp_board.sv
/* Board model on the port pins: pull-ups and external drivers.
 Assumes oe high means the block sinks the pin. */
`default_nettype none
module dpp_board (
    input  wire logic [7:0] p1_oe,
    input  wire logic [2:0] p2_oe,
    input  wire logic [7:0] p1_ext,
    input  wire logic [2:0] p2_ext,
    output logic      [7:0] p1_pad,
    output logic      [2:0] p2_pad
);
    // Wired-AND: pull-up wins unless block or board sinks; bench holds ext until read
    assign p1_pad = p1_ext & ~p1_oe;
    assign p2_pad = p2_ext & ~p2_oe;
endmodule : dpp_board
`default_nettype wire

//--- dpp_ports_tb_top.sv
/* Self-checking bench for dpp_ports with board model and bound checker.
 Assumes 100 MHz clk_sys and synchronous active-high rst. */
`default_nettype none
module dpp_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0, rst = 1, rd = 0, wr = 0, en = 1, dual = 0, stop = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata, p1_oe, p1_pad, seg, p1_ext = 8'hFF;
    logic [2:0]  p2_oe, p2_pad, p2_ext = 3'h7;
    logic        osc_in, fall, rel;
    logic [7:0]  p1_out;
    int          fail_count = 0, samples_checked = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    dpp_ports dut_u (.clk_sys, .rst, .cpu_addr(addr), .cpu_wdata(wdata), .cpu_rd_sample(rd),
        .cpu_wr_update(wr), .cpu_rdata(rdata), .port_output_enable(en),
        .dual_clock_mode(dual), .stop_mode(stop), .port1_in(p1_pad), .port1_out(p1_out),
        .port1_oe(p1_oe), .port1_lcd_seg_en(seg), .port2_in(p2_pad), .port2_out(),
        .port2_oe(p2_oe), .low_freq_osc_in(osc_in), .low_freq_osc_out(1'b0),
        .port2_bit0_fall(fall), .stop_release(rel));
    dpp_board board_u (.p1_oe, .p2_oe, .p1_ext, .p2_ext, .p1_pad, .p2_pad);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Gap cycle after each strobe so no strobe is assigned twice in one step
    // Whole-byte writes only, never read-modify-write
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr = a; wdata = d; wr = 1;
        @(posedge clk_sys) #1 wr = 0;
        @(posedge clk_sys) #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        addr = a; rd = 1;
        @(posedge clk_sys) #1 rd = 0;
        d = rdata;
        @(posedge clk_sys) #1;
    endtask : rd_reg
    task automatic finish_test;
        $display("compared %0d wrong %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic t_reset;
        logic [7:0] d;
        rd_reg(16'h0001, d);
        chk("p1 latch", 8'hFF, d);
        rd_reg(16'h0002, d);
        chk("p2 latch", 8'h07, d);
        chk("p1 oe", 8'h00, p1_oe);
        chk("p1 out", 8'h00, p1_out);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_port1;
        logic [7:0] d;
        wr_reg(16'h0001, 8'h5A);
        chk("p1 oe", 8'hA5, p1_oe);
        wr_reg(16'h0041, 8'h00);
        rd_reg(16'h0001, d);
        chk("p1 latch", 8'h5A, d);
        rd_reg(16'h0008, d);
        chk("p1 pins", 8'h5A, d);
        wr_reg(16'h0029, 8'h0F);
        chk("p1 seg oe", 8'hA0, p1_oe);
        chk("p1 seg en", 8'h0F, seg);
        $display("t_port1 done");
    endtask : t_port1
    task automatic t_port2;
        logic [7:0] d;
        wr_reg(16'h0002, 8'h00);
        chk("p2 oe", 8'h07, {5'h00, p2_oe});
        chk("p2 fall", 8'h01, {7'h00, fall});
        dual = 1;
        #10 chk("p2 osc oe", 8'h01, {5'h00, p2_oe});
        stop = 1;
        #30 chk("p2 stop oe", 8'h00, {5'h00, p2_oe});
        chk("stop release", 8'h01, {7'h00, rel});
        chk("osc in", 8'h01, {7'h00, osc_in});
        rd_reg(16'h0009, d);
        chk("p2 pins", 8'h07, d);
        $display("t_port2 done");
    endtask : t_port2
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst = 0;
        t_reset();
        t_port1();
        t_port2();
        finish_test();
    end
endmodule : dpp_ports_tb_top
bind dpp_ports dpp_ports_assertions chk_u (.clk_sys, .rst, .cpu_addr, .cpu_wdata,
    .cpu_rd_sample, .cpu_wr_update, .cpu_rdata, .port_output_enable, .dual_clock_mode,
    .stop_mode, .port1_oe, .port1_lcd_seg_en, .port2_out, .port2_oe, .port2_bit0_fall);
`default_nettype wire
